// ===== src/dma_channel_control_enable.sv
// Four-channel DMA request, enable and arbitration control
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module dma_channel_control_enable (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Requesters, active low; NMI_IN active high
   input wire logic [1:0] EXT_XFER_REQ_IN_N,
   input wire logic [1:0] PERIPH_REQ_N,
   input wire logic NMI_IN,
   // Transfer engine side
   output logic XFER_STROBE,
   output logic [1:0] XFER_CH,
   output logic [1:0] XFER_SIZE,
   output logic XFER_BURST,
   output logic [1:0] PERIPH_ACK,
   output logic [3:0] END_IRQ
);

   // ----------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------
   dma_pkg::reg_req_t req;
   dma_pkg::chan_ctl_t ctl [dma_pkg::NUM_CH];
   dma_pkg::chan_ctl_t wr_cc;
   dma_pkg::op_ctl_t op;
   dma_pkg::xfer_state_t state;
   logic [dma_pkg::CNT_W-1:0] count [dma_pkg::NUM_CH];
   logic [3:0] sel_cc, sel_cnt;
   logic sel_op;
   logic [3:0] te_seen;
   logic nmi_flag_seen;
   logic [3:0] ext_n4, per_n4, pin_n, pin_q;
   logic [3:0] is_auto, is_ext, is_per, use_edge;
   logic [3:0] armed, edge_pend, level_req;
   logic [3:0] permit, want, done, serve;
   logic [1:0] burst_ch, last_ch, grant_ch;
   logic grant_any;
   logic [2:0] pick_res;

   assign req = '{addr: REG_ADDR, wdata: REG_WDATA,
                  wr: REG_WR, rd: REG_RD};
   assign wr_cc = dma_pkg::chan_ctl_t'(REG_WDATA[11:0]);
   // Channels 2 and 3 have no pins; idle high
   assign ext_n4 = {2'h3, EXT_XFER_REQ_IN_N};
   assign per_n4 = {2'h3, PERIPH_REQ_N};

   // ----------------------------------------------------------
   // Arbitration order
   // ----------------------------------------------------------
   function automatic logic [2:0] pick(input logic [3:0] w,
                                       input logic [1:0] pr,
                                       input logic [1:0] last);
      logic [7:0] ord;
      logic [1:0] c;
      logic [2:0] res;
      unique case (pr)
         dma_pkg::PR_FIX_0123: ord = dma_pkg::ORDER_0123;
         dma_pkg::PR_FIX_0231: ord = dma_pkg::ORDER_0231;
         dma_pkg::PR_FIX_2013: ord = dma_pkg::ORDER_2013;
         dma_pkg::PR_ROUND: begin
            // Served channel drops to the back
            ord = {last, 2'(last + 2'h3), 2'(last + 2'h2),
                   2'(last + 2'h1)};
         end
      endcase
      res = 3'h0;
      // Scan lowest first so the highest wins
      for (int k = 3; k >= 0; k--) begin
         c = ord[2*k +: 2];
         if (w[c]) begin
            res = {1'b1, c};
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------
   always_comb begin
      sel_op = req.addr == dma_pkg::OPCTL_ADDR;
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
         sel_cc[i] = req.addr ==
            8'(dma_pkg::CHCTL_BASE + dma_pkg::CH_STRIDE * i);
         sel_cnt[i] = req.addr ==
            8'(dma_pkg::COUNT_BASE + dma_pkg::CH_STRIDE * i);
      end
   end

   // ----------------------------------------------------------
   // Request qualification
   // ----------------------------------------------------------
   always_comb begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
         // NMI pin blocks at once, before its flag lands
         permit[i] = ctl[i].de & op.master_enable & ~ctl[i].te & ~op.nmi_flag
                     & ~NMI_IN;
         is_auto[i] = ctl[i].rs == dma_pkg::RS_AUTO;
         is_ext[i] = (i < 2) && ctl[i].rs == dma_pkg::RS_EXT;
         is_per[i] = (i < 2)
                     && ctl[i].rs >= dma_pkg::RS_PERIPH_MIN;
         pin_n[i] = is_ext[i] ? ext_n4[i] : per_n4[i];
         use_edge[i] = is_per[i] | ctl[i].ds;
         level_req[i] = is_ext[i] & ~use_edge[i] & armed[i]
                        & ~pin_n[i];
         want[i] = permit[i] & (is_auto[i] | level_req[i]
                   | ((is_ext[i] | is_per[i]) & use_edge[i]
                   & edge_pend[i]));
      end
   end

   // ----------------------------------------------------------
   // Grant selection
   // ----------------------------------------------------------
   always_comb begin
      pick_res = pick(want, op.pr, last_ch);
      grant_any = 1'b0;
      grant_ch = 2'h0;
      // A burst owner keeps the bus while it still asks
      if (state == dma_pkg::ST_BURST && want[burst_ch]) begin
         grant_any = 1'b1;
         grant_ch = burst_ch;
      end else if (pick_res[2]) begin
         grant_any = 1'b1;
         grant_ch = pick_res[1:0];
      end
   end

   always_comb begin
      for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
         done[i] = grant_any && grant_ch == 2'(i)
                   && count[i] == dma_pkg::COUNT_LAST;
         serve[i] = grant_any && grant_ch == 2'(i)
                    && (!ctl[i].tm || done[i]);
      end
   end

   // ----------------------------------------------------------
   // Pin history and pending requests
   // ----------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pin_q <= 4'hF;
         armed <= 4'h0;
      end else begin
         pin_q <= pin_n;
         // A level already low at enable must first go high
         armed <= {ctl[3].de, ctl[2].de, ctl[1].de, ctl[0].de}
                  & (armed | pin_n);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         edge_pend <= 4'h0;
      end else begin
         for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            // Edges seen while not permitted are dropped
            if (!permit[i]) begin
               edge_pend[i] <= 1'b0;
            end else if (use_edge[i] && pin_q[i] && !pin_n[i]) begin
               edge_pend[i] <= 1'b1;
            end else if (serve[i]) begin
               edge_pend[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------
   // Transfer sequencing
   // ----------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= dma_pkg::ST_IDLE;
         burst_ch <= 2'h0;
      end else begin
         unique case (state)
            dma_pkg::ST_IDLE: begin
               if (grant_any && ctl[grant_ch].tm
                   && !done[grant_ch]) begin
                  state <= dma_pkg::ST_BURST;
                  burst_ch <= grant_ch;
               end
            end
            dma_pkg::ST_BURST: begin
               if (!(grant_any && grant_ch == burst_ch
                     && !done[burst_ch])) begin
                  state <= dma_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         last_ch <= 2'h3;
      end else if (grant_any) begin
         last_ch <= grant_ch;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            count[i] <= dma_pkg::COUNT_RESET;
         end
      end else begin
         for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            // Software load beats a same-cycle decrement
            if (req.wr && sel_cnt[i]) begin
               count[i] <= req.wdata[dma_pkg::CNT_W-1:0];
            end else if (grant_any && grant_ch == 2'(i)) begin
               count[i] <= count[i] - dma_pkg::COUNT_LAST;
            end
         end
      end
   end

   // ----------------------------------------------------------
   // Channel control registers
   // ----------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            ctl[i] <= dma_pkg::chan_ctl_t'(dma_pkg::CHCTL_RESET);
         end
         te_seen <= 4'h0;
      end else begin
         for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            if (req.wr && sel_cc[i]) begin
               ctl[i].rs <= wr_cc.rs;
               ctl[i].ds <= (i < 2) ? wr_cc.ds : 1'b0;
               ctl[i].tm <= wr_cc.tm;
               ctl[i].ts <= wr_cc.ts;
               ctl[i].ie <= wr_cc.ie;
               ctl[i].de <= wr_cc.de;
            end
            // Completion wins over a same-cycle clear
            if (done[i]) begin
               ctl[i].te <= 1'b1;
            end else if (req.wr && sel_cc[i] && !wr_cc.te
                         && te_seen[i]) begin
               ctl[i].te <= 1'b0;
            end
            if (req.wr && sel_cc[i]) begin
               te_seen[i] <= 1'b0;
            end else if (req.rd && sel_cc[i] && ctl[i].te) begin
               te_seen[i] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------
   // Operation register
   // ----------------------------------------------------------
   // No standby input; contents simply hold
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         op <= dma_pkg::op_ctl_t'(dma_pkg::OPCTL_RESET);
         nmi_flag_seen <= 1'b0;
      end else begin
         if (req.wr && sel_op) begin
            op.pr <= req.wdata[dma_pkg::OP_PR +: 2];
            op.master_enable <= req.wdata[dma_pkg::OP_DME];
         end
         if (NMI_IN) begin
            op.nmi_flag <= 1'b1;
         end else if (req.wr && sel_op && nmi_flag_seen
                      && !req.wdata[dma_pkg::OP_NMI_FLAG]) begin
            op.nmi_flag <= 1'b0;
         end
         if (req.wr && sel_op) begin
            nmi_flag_seen <= 1'b0;
         end else if (req.rd && sel_op && op.nmi_flag) begin
            nmi_flag_seen <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------
   // Read data and outputs
   // ----------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RDATA <= 32'h0;
      end else begin
         REG_RDATA <= 32'h0;
         if (req.rd) begin
            if (sel_op) begin
               REG_RDATA <= 32'(op);
            end
            for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
               if (sel_cc[i]) begin
                  REG_RDATA <= 32'(ctl[i]);
               end
               if (sel_cnt[i]) begin
                  REG_RDATA <= 32'(count[i]);
               end
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         XFER_STROBE <= 1'b0;
         XFER_CH <= 2'h0;
         XFER_SIZE <= dma_pkg::SIZE_8;
         XFER_BURST <= 1'b0;
      end else begin
         XFER_STROBE <= grant_any;
         XFER_CH <= grant_ch;
         XFER_SIZE <= ctl[grant_ch].ts;
         XFER_BURST <= ctl[grant_ch].tm;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PERIPH_ACK <= 2'h0;
         END_IRQ <= 4'h0;
      end else begin
         // Withdraw after first unit, or after last in burst
         PERIPH_ACK <= serve[1:0] & is_per[1:0];
         for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            END_IRQ[i] <= ctl[i].te & ctl[i].ie;
         end
      end
   end

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   sequence s_te_read;
      req.rd && sel_cc[0] && ctl[0].te;
   endsequence

   sequence s_te_zero;
      req.wr && sel_cc[0] && !req.wdata[dma_pkg::CC_TE];
   endsequence

   a_te_clear:
   assert property (s_te_read ##1 s_te_zero |=> !ctl[0].te)
      else $error("end flag not cleared after read");

   a_te_sticky:
   assert property (ctl[0].te && !(req.wr && sel_cc[0])
                    |=> ctl[0].te)
      else $error("end flag dropped without write");

   a_te_only_end:
   assert property (!ctl[1].te && !done[1] |=> !ctl[1].te)
      else $error("end flag set without completion");

   a_te_on_end:
   assert property (done[0] && !(req.wr && sel_cnt[0])
                    |=> ctl[0].te && count[0] == 24'h0)
      else $error("completion did not set end flag");

   a_ds_upper:
   assert property (req.rd && (sel_cc[2] || sel_cc[3])
                    |=> !REG_RDATA[dma_pkg::CC_DS])
      else $error("sense bit visible on channel 2 or 3");

   a_op_resv:
   assert property (req.rd && sel_op
                    |=> REG_RDATA[15:10] == 6'h00
                        && REG_RDATA[7:2] == 6'h00)
      else $error("reserved operation bits nonzero");

   a_permit_gate:
   assert property (grant_any |-> permit[grant_ch])
      else $error("grant to channel not permitted");

   a_master_off:
   assert property (!op.master_enable |-> !grant_any ##1 !XFER_STROBE)
      else $error("transfer with master enable low");

   a_nmi_block:
   assert property (NMI_IN |-> !grant_any ##1 (op.nmi_flag && !grant_any))
      else $error("transfer during NMI");

   a_nmi_sticky:
   assert property (op.nmi_flag && !(req.wr && sel_op) |=> op.nmi_flag)
      else $error("NMI flag dropped without write");

   a_src_upper:
   assert property (grant_any && grant_ch[1] |-> is_auto[grant_ch])
      else $error("non-auto source on channel 2 or 3");

   a_fix_order:
   assert property (op.pr == dma_pkg::PR_FIX_2013
                    && state == dma_pkg::ST_IDLE && want[2]
                    |-> grant_ch == 2'h2)
      else $error("fixed order not honoured");

   a_rr_last:
   assert property (op.pr == dma_pkg::PR_ROUND && grant_any
                    |=> last_ch == $past(grant_ch))
      else $error("rotation pointer not updated");

   a_irq_mask:
   assert property (!ctl[0].ie |=> !END_IRQ[0])
      else $error("end irq while disabled");

   a_level_sense:
   assert property (permit[0] && is_ext[0] && !ctl[0].ds
                    && armed[0] && !pin_n[0] |-> want[0])
      else $error("low level not recognised");

   a_periph_edge:
   assert property (is_per[1] && !pin_n[1] && !pin_q[1]
                    && !edge_pend[1] |-> !want[1])
      else $error("peripheral held level taken as request");

   a_auto_start:
   assert property (permit[0] && is_auto[0] |-> want[0])
      else $error("auto request not started");

   a_arm_fresh:
   assert property ($rose(ctl[1].de) |-> !armed[1])
      else $error("stale request armed at enable");

   a_enable_drop:
   assert property (!ctl[0].de |-> !want[0] ##1 !edge_pend[0])
      else $error("channel requests while disabled");

endmodule

// ===== src/dma_pkg.sv
// Constants and types for the four-channel DMA control block
//
// Contract
// - Sense select exists on channels 0, 1 only
// - Sense 0 low level, 1 falling edge
// - Peripheral source always uses falling edge
// - External and peripheral sources only on 0, 1
// - Bus mode 0 cycle steal, 1 burst
// - Size 00 byte, 01 word, 10 long
// - End irq raised only when enabled
// - End flag set when count completes
// - Aborted transfer leaves end flag clear
// - End flag cleared by 0 after 1 read
// - Permit needs enables, no end, no NMI
// - Auto request starts once enabled
// - Only requests after enable start transfers
// - Clearing channel enable stops its transfer
// - Operation reserved bits ignore writes, read 0
// - Operation register resets to zero
// - Priority mode picks fixed orders or rotation
// - NMI sets flag, blocks all channels
// - NMI flag cleared by 0 after 1 read
// - Clearing master enable stops all channels
// - Count decrements per unit, ends at zero
// - NMI aborts any running transfer
package dma_pkg;
   localparam int NUM_CH = 4;
   localparam int CNT_W = 24;
   // Register map
   localparam logic [7:0] CHCTL_BASE = 8'h00;
   localparam logic [7:0] COUNT_BASE = 8'h10;
   localparam logic [7:0] OPCTL_ADDR = 8'h20;
   localparam logic [7:0] CH_STRIDE = 8'h04;
   // Field positions
   localparam int CC_DE = 0;
   localparam int CC_TE = 1;
   localparam int CC_IE = 2;
   localparam int CC_TS = 3;
   localparam int CC_TM = 5;
   localparam int CC_DS = 6;
   localparam int CC_RS = 8;
   localparam int OP_DME = 0;
   localparam int OP_NMI_FLAG = 1;
   localparam int OP_PR = 8;
   // Encodings
   localparam logic [3:0] RS_EXT = 4'h0;
   localparam logic [3:0] RS_AUTO = 4'h4;
   localparam logic [3:0] RS_PERIPH_MIN = 4'hA;
   localparam logic [1:0] SIZE_8 = 2'h0;
   localparam logic [1:0] SIZE_16 = 2'h1;
   localparam logic [1:0] SIZE_32 = 2'h2;
   localparam logic [1:0] PR_FIX_0123 = 2'h0;
   localparam logic [1:0] PR_FIX_0231 = 2'h1;
   localparam logic [1:0] PR_FIX_2013 = 2'h2;
   localparam logic [1:0] PR_ROUND = 2'h3;
   // Channel order, highest first in the low pair
   localparam logic [7:0] ORDER_0123 = 8'hE4;
   localparam logic [7:0] ORDER_0231 = 8'h78;
   localparam logic [7:0] ORDER_2013 = 8'hD2;
   // Reset values
   localparam logic [11:0] CHCTL_RESET = 12'h000;
   localparam logic [15:0] OPCTL_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] COUNT_RESET = 24'h000000;
   localparam logic [CNT_W-1:0] COUNT_LAST = 24'h000001;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] rs;
      logic rsv;
      logic ds;
      logic tm;
      logic [1:0] ts;
      logic ie;
      logic te;
      logic de;
   } chan_ctl_t;

   typedef struct packed {
      logic [5:0] rsv_hi;
      logic [1:0] pr;
      logic [5:0] rsv_lo;
      logic nmi_flag;
      logic master_enable;
   } op_ctl_t;

   typedef enum logic {ST_IDLE, ST_BURST} xfer_state_t;
endpackage

// ===== tb/dma_requester_model.sv
// Requester model for the external and peripheral request pins
`timescale 1ns/1ns
module dma_requester_model (
   // Clock
   input wire logic clk,
   // Request pins, active low, pulled up when idle
   output logic [1:0] ext_req_n,
   output logic [1:0] periph_req_n,
   // Withdraw pulses from the block
   input wire logic [1:0] periph_ack
);
   initial begin
      ext_req_n = 2'h3;
      periph_req_n = 2'h3;
   end
   // High first, so the fall is a fresh request
   task automatic ext_pulse(input int ch, input int n);
      @(posedge clk) ext_req_n[ch] <= 1'b1;
      repeat (3) @(posedge clk);
      ext_req_n[ch] <= 1'b0;
      repeat (n) @(posedge clk);
      ext_req_n[ch] <= 1'b1;
   endtask
   // Held until the block withdraws it
   task automatic periph_req(input int ch);
      int k;
      @(posedge clk) periph_req_n[ch] <= 1'b0;
      for (k = 0; k < 20 && periph_ack[ch] !== 1'b1; k++) @(posedge clk);
      periph_req_n[ch] <= 1'b1;
   endtask
endmodule

// ===== tb/tb_dma_channel_control_enable.sv
// Self-checking bench for the DMA control and enable block
`timescale 1ns/1ns
module tb_dma_channel_control_enable;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam logic [7:0] OP = dma_pkg::OPCTL_ADDR;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic nmi_in = 1'b0;
   logic [31:0] reg_rdata;
   logic [1:0] ext_req_n;
   logic [1:0] periph_req_n;
   logic xfer_strobe;
   logic [1:0] xfer_ch;
   logic [1:0] xfer_size;
   logic xfer_burst;
   logic [1:0] periph_ack;
   logic [3:0] end_irq;
   logic [1:0] last_size;
   logic last_burst;
   logic [1:0] hist[$];
   int n_str[4] = '{0, 0, 0, 0};
   int base[4];
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;
   int got;
   int n_ack = 0;

   always #4 sys_clk = ~sys_clk;

   dma_channel_control_enable dut (.SYS_CLK(sys_clk), .RSTN(rstn),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .EXT_XFER_REQ_IN_N(ext_req_n), .PERIPH_REQ_N(periph_req_n),
      .NMI_IN(nmi_in), .XFER_STROBE(xfer_strobe), .XFER_CH(xfer_ch),
      .XFER_SIZE(xfer_size), .XFER_BURST(xfer_burst),
      .PERIPH_ACK(periph_ack), .END_IRQ(end_irq));

   dma_requester_model partner (.clk(sys_clk), .ext_req_n(ext_req_n),
      .periph_req_n(periph_req_n), .periph_ack(periph_ack));

   // Unit log; a hang ends the run well past the expected length
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (xfer_strobe === 1'b1) begin
         n_str[xfer_ch] <= n_str[xfer_ch] + 1;
         last_size <= xfer_size;
         last_burst <= xfer_burst;
         hist.push_back(xfer_ch);
      end
      if (periph_ack[1] === 1'b1) begin
         n_ack <= n_ack + 1;
      end
      if (cycles == 20000) begin
         n_fail++;
         close_out();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic close_out();
      $display("Checks made %0d, failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic do_reset();
      @(posedge sys_clk) rstn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk) rstn <= 1'b1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   function automatic logic [7:0] ctl(input int ch);
      return 8'(dma_pkg::CHCTL_BASE + ch * dma_pkg::CH_STRIDE);
   endfunction
   function automatic logic [7:0] cnt(input int ch);
      return 8'(dma_pkg::COUNT_BASE + ch * dma_pkg::CH_STRIDE);
   endfunction
   task automatic mark();
      base = n_str;
      hist.delete();
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic cnt_chk(input int ch, input int e);
      chk(32'(n_str[ch] - base[ch]), 32'(e));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd_chk(OP, 32'h0);
      rd_chk(8'h30, 32'h0);
      wr(OP, 32'hFFFFFFFF);
      rd_chk(OP, 32'h00000301);
      wr(OP, 32'h0);
      wr(ctl(2), 32'h00000040);
      rd_chk(ctl(2), 32'h0);
      wr(ctl(0), 32'h00000060);
      rd_chk(ctl(0), 32'h00000060);
      wr(ctl(0), 32'h0);
   endtask
   task automatic t_auto();
      wr(cnt(0), 32'h2);
      wr(ctl(0), 32'h0000042D);
      mark();
      wr(OP, 32'h1);
      wait_n(8);
      cnt_chk(0, 2);
      chk(32'(last_size), 32'(dma_pkg::SIZE_16));
      chk(32'(last_burst), 32'h1);
      chk(32'(end_irq), 32'h1);
      wr(cnt(0), 32'h1);
      wr(ctl(0), 32'h0000042D);
      wait_n(5);
      cnt_chk(0, 2);
      rd_chk(ctl(0), 32'h0000042F);
      wr(ctl(0), 32'h00000409);
      wait_n(8);
      cnt_chk(0, 3);
      chk(32'(last_burst), 32'h0);
      chk(32'(end_irq), 32'h0);
      do_reset();
   endtask
   task automatic t_abort();
      wr(cnt(0), 32'h64);
      wr(ctl(0), 32'h00000401);
      mark();
      wr(OP, 32'h1);
      wait_n(3);
      wr(ctl(0), 32'h00000400);
      wait_n(2);
      got = n_str[0] - base[0];
      wait_n(5);
      chk(32'(got > 0), 32'h1);
      cnt_chk(0, got);
      rd_chk(ctl(0), 32'h00000400);
      wr(cnt(1), 32'h64);
      wr(ctl(1), 32'h00000401);
      wait_n(3);
      wr(OP, 32'h0);
      wait_n(2);
      got = n_str[1] - base[1];
      wait_n(5);
      cnt_chk(1, got);
      rd_chk(ctl(1), 32'h00000401);
   endtask
   task automatic t_nmi();
      do_reset();
      wr(cnt(1), 32'h64);
      wr(ctl(1), 32'h00000401);
      mark();
      wr(OP, 32'h1);
      @(posedge sys_clk) nmi_in <= 1'b1;
      @(posedge sys_clk) nmi_in <= 1'b0;
      wait_n(2);
      got = n_str[1] - base[1];
      wait_n(5);
      cnt_chk(1, got);
      wr(OP, 32'h1);
      rd_chk(OP, 32'h3);
      rd_chk(ctl(1), 32'h00000401);
      wr(OP, 32'h3);
      rd_chk(OP, 32'h3);
      wr(OP, 32'h1);
      rd_chk(OP, 32'h1);
      wait_n(110);
      rd_chk(ctl(1), 32'h00000403);
   endtask
   task automatic t_ext();
      do_reset();
      wr(cnt(0), 32'h2);
      wr(ctl(0), 32'h00000001);
      wr(cnt(2), 32'h1);
      wr(ctl(2), 32'h00000001);
      mark();
      wr(OP, 32'h1);
      partner.ext_pulse(0, 12);
      wait_n(4);
      cnt_chk(0, 2);
      cnt_chk(2, 0);
      rd_chk(ctl(0), 32'h00000003);
      wr(cnt(0), 32'h3);
      wr(ctl(0), 32'h00000041);
      partner.ext_pulse(0, 12);
      wait_n(4);
      cnt_chk(0, 3);
      wr(cnt(0), 32'h3);
      wr(ctl(0), 32'h00000061);
      partner.ext_pulse(0, 2);
      wait_n(4);
      cnt_chk(0, 6);
      wr(cnt(1), 32'h2);
      wr(ctl(1), 32'h00000A01);
      partner.periph_req(1);
      partner.periph_req(1);
      wait_n(4);
      cnt_chk(1, 2);
      rd_chk(ctl(1), 32'h00000A03);
      chk(32'(n_ack), 32'h2);
   endtask
   task automatic t_prio();
      logic [7:0] e[4] = '{8'h5A, 8'hAF, 8'hA5, 8'h6D};
      for (int m = 0; m < 4; m++) begin
         do_reset();
         wr(cnt(1), 32'h2);
         wr(cnt(2), 32'h2);
         wr(cnt(3), 32'h2);
         wr(ctl(1), 32'h00000401);
         wr(ctl(2), 32'h00000401);
         wr(ctl(3), 32'h00000401);
         mark();
         wr(OP, {22'h0, m[1:0], 8'h01});
         wait_n(8);
         chk(32'({hist[0], hist[1], hist[2], hist[3]}),
             32'(e[m]));
      end
   endtask

   initial begin
      do_reset();
      t_regs();
      t_auto();
      t_abort();
      t_nmi();
      t_ext();
      t_prio();
      close_out();
   end
endmodule
